// file: design/cmb_consts.vh
`ifndef CMB_CONSTS_VH
`define CMB_CONSTS_VH

// ****************************************
// address map
// ****************************************
`define CMB_ADDR_W 12
`define CMB_MB_REGION 3'h1
`define CMB_OFF_MODE 5'h00
`define CMB_OFF_STAT 5'h10
`define CMB_OFF_PLOW 5'h14
`define CMB_OFF_PHIGH 5'h18
`define CMB_OFF_CMD 5'h1c

// ****************************************
// decoded register codes
// ****************************************
`define CMB_REG_NONE 3'h0
`define CMB_REG_MODE 3'h1
`define CMB_REG_STAT 3'h2
`define CMB_REG_PLOW 3'h3
`define CMB_REG_PHIGH 3'h4
`define CMB_REG_CMD 3'h5

// ****************************************
// field positions
// ****************************************
`define CMB_MOT_LSB 24
`define CMB_MOT_MSB 26
`define CMB_PRIO_LSB 16
`define CMB_PRIO_MSB 19
`define CMB_MMI_BIT 24
`define CMB_RDY_BIT 23
`define CMB_ABT_BIT 22
`define CMB_TCR_BIT 23
`define CMB_ACR_BIT 22
`define CMB_RTR_BIT 20
`define CMB_DLC_LSB 16
`define CMB_DLC_MSB 19

// ****************************************
// object types
// ****************************************
`define CMB_MOT_OFF 3'h0
`define CMB_MOT_RX 3'h1
`define CMB_MOT_RXOV 3'h2
`define CMB_MOT_TX 3'h3
`define CMB_MOT_CONS 3'h4
`define CMB_MOT_PROD 3'h5

// ****************************************
// reset values
// ****************************************
`define CMB_ZERO32 32'h00000000
`define CMB_ZERO4 4'h0

`endif

// file: design/cmb_tx_arbiter.v
`timescale 1ns/1ns
// ****************************************
// transmit arbiter
// ****************************************
// lowest priority value wins; ties go to the lowest mailbox number
module cmb_tx_arbiter #(
	parameter NUM_MB = 8,
	parameter MB_W = 3,
	parameter PRIO_W = 4
) (
	// requests
	input wire [NUM_MB-1:0] req,
	input wire [NUM_MB*PRIO_W-1:0] prio,
	// grant
	output reg any,
	output reg [MB_W-1:0] grant
);
	integer k;
	reg [PRIO_W-1:0] best;

	always @* begin
		any = 1'b0;
		grant = {MB_W{1'b0}};
		best = {PRIO_W{1'b1}};
		// strict less-than keeps the lower number on a tie
		for (k = 0; k < NUM_MB; k = k + 1) begin
			if (req[k] && (!any || prio[k*PRIO_W +: PRIO_W] < best)) begin
				any = 1'b1;
				best = prio[k*PRIO_W +: PRIO_W];
				grant = k[MB_W-1:0];
			end
		end
	end
endmodule

// file: design/cmb_mailbox.v
`timescale 1ns/1ns
`include "cmb_consts.vh"

module cmb_mailbox #(
	parameter NUM_MB = 8,
	parameter MB_W = 3,
	parameter PRIO_W = 4
) (
	// clock and reset
	input wire clock,
	input wire arst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`CMB_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// frames offered by the protocol engine
	input wire rx_valid,
	input wire [MB_W-1:0] rx_mb,
	input wire rx_rtr,
	input wire [3:0] rx_dlc,
	input wire [63:0] rx_data,
	output reg rx_taken,
	output reg rx_ignored,
	// transmit request to the protocol engine
	output reg tx_req,
	output reg [MB_W-1:0] tx_mb,
	output reg tx_rtr,
	output reg [3:0] tx_dlc,
	output reg [63:0] tx_data,
	input wire tx_start,
	input wire tx_done,
	// per-mailbox interrupt levels
	output reg [NUM_MB-1:0] mb_irq
);

	// ****************************************
	// address decode
	// ****************************************
	function [2:0] reg_decode;
		input [`CMB_ADDR_W-1:0] a;
		begin
			if (a[11:9] != `CMB_MB_REGION)
				reg_decode = `CMB_REG_NONE;
			else if (a[4:0] == `CMB_OFF_MODE)
				reg_decode = `CMB_REG_MODE;
			else if (a[4:0] == `CMB_OFF_STAT)
				reg_decode = `CMB_REG_STAT;
			else if (a[4:0] == `CMB_OFF_PLOW)
				reg_decode = `CMB_REG_PLOW;
			else if (a[4:0] == `CMB_OFF_PHIGH)
				reg_decode = `CMB_REG_PHIGH;
			else if (a[4:0] == `CMB_OFF_CMD)
				reg_decode = `CMB_REG_CMD;
			else
				reg_decode = `CMB_REG_NONE;
		end
	endfunction

	// an index past the last mailbox decodes to nothing and answers with an error
	wire [3:0] acc_idx = paddr[8:5];
	wire idx_ok = ({1'b0, acc_idx} < NUM_MB);
	wire [2:0] acc_reg = idx_ok ? reg_decode(paddr) : `CMB_REG_NONE;
	wire [MB_W-1:0] acc_mb = acc_idx[MB_W-1:0];
	wire setup = psel && !penable;
	wire done_acc = psel && penable && pready;
	wire wr_done = done_acc && pwrite && !pslverr;
	wire rd_done = done_acc && !pwrite && !pslverr;

	// flattened per-mailbox views
	wire [NUM_MB*32-1:0] stat_w;
	wire [NUM_MB*32-1:0] mode_w;
	wire [NUM_MB*64-1:0] pay_w;
	wire [NUM_MB-1:0] rdy_w;
	wire [NUM_MB-1:0] req_w;
	wire [NUM_MB-1:0] take_w;
	wire [NUM_MB-1:0] irq_d;
	wire [NUM_MB*PRIO_W-1:0] prio_w;
	wire [NUM_MB*3-1:0] mot_w;
	wire [NUM_MB-1:0] rtr_w;
	wire [NUM_MB*4-1:0] dlc_w;
	reg busy_q;
	reg [MB_W-1:0] cur_mb_q;

	// ****************************************
	// mailboxes
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < NUM_MB; i = i + 1) begin : g_mb
			reg [2:0] object_type_field_q;
			reg [PRIO_W-1:0] prio_q;
			reg mailbox_ready_flag_q;
			reg mailbox_abort_flag_q;
			reg message_ignored_flag_q;
			reg remote_request_bit_q;
			reg [3:0] length_code_field_q;
			reg [31:0] payload_low_value_q;
			reg [31:0] payload_high_value_q;
			reg armed_q;
			reg rsent_q;
			reg pend_q;

			wire sel = (acc_mb == i);
			wire wr_mode = wr_done && sel && acc_reg == `CMB_REG_MODE;
			wire wr_cmd = wr_done && sel && acc_reg == `CMB_REG_CMD;
			wire wr_low = wr_done && sel && acc_reg == `CMB_REG_PLOW;
			wire wr_high = wr_done && sel && acc_reg == `CMB_REG_PHIGH;
			wire rd_stat = rd_done && sel && acc_reg == `CMB_REG_STAT;
			wire [2:0] new_mot = pwdata[`CMB_MOT_MSB:`CMB_MOT_LSB];
			wire is_rx = object_type_field_q == `CMB_MOT_RX;
			wire is_rxov = object_type_field_q == `CMB_MOT_RXOV;
			wire is_tx = object_type_field_q == `CMB_MOT_TX;
			wire is_cons = object_type_field_q == `CMB_MOT_CONS;
			wire is_prod = object_type_field_q == `CMB_MOT_PROD;
			wire hit = rx_valid && rx_mb == i;
			// a consumer listens only once its remote frame is out
			wire first_kind = armed_q && (is_rx || (is_cons && rsent_q));
			wire take_first = hit && first_kind && !mailbox_ready_flag_q;
			wire take_over = hit && armed_q && is_rxov;
			wire store = take_first || take_over;
			wire prod_hit = hit && is_prod && rx_rtr;
			wire prod_take = prod_hit && armed_q && !pend_q;
			wire ign_set = (hit && first_kind && mailbox_ready_flag_q)
				|| (take_over && mailbox_ready_flag_q)
				|| (prod_hit && !armed_q);
			wire starting = tx_start && tx_req && tx_mb == i;
			wire inflight = (busy_q && cur_mb_q == i) || starting;
			wire sent = tx_done && busy_q && cur_mb_q == i;
			// once on the wire the frame can no longer be recalled
			wire abort_ok = wr_cmd && pwdata[`CMB_ACR_BIT] && armed_q && !inflight
				&& (is_tx || is_prod || (is_cons && !rsent_q));

			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					object_type_field_q <= `CMB_MOT_OFF;
					prio_q <= {PRIO_W{1'b0}};
					mailbox_ready_flag_q <= 1'b0;
					mailbox_abort_flag_q <= 1'b0;
					message_ignored_flag_q <= 1'b0;
					remote_request_bit_q <= 1'b0;
					length_code_field_q <= `CMB_ZERO4;
					payload_low_value_q <= `CMB_ZERO32;
					payload_high_value_q <= `CMB_ZERO32;
					armed_q <= 1'b0;
					rsent_q <= 1'b0;
					pend_q <= 1'b0;
				end else begin
					if (wr_mode) begin
						object_type_field_q <= new_mot;
						prio_q <= pwdata[`CMB_PRIO_LSB +: PRIO_W];
						mailbox_ready_flag_q <= (new_mot == `CMB_MOT_TX)
							|| (new_mot == `CMB_MOT_PROD);
						mailbox_abort_flag_q <= 1'b0;
						remote_request_bit_q <= (new_mot == `CMB_MOT_CONS);
						armed_q <= 1'b0;
						rsent_q <= 1'b0;
						pend_q <= 1'b0;
					end else begin
						if (wr_cmd) begin
							mailbox_ready_flag_q <= 1'b0;
							mailbox_abort_flag_q <= abort_ok;
							if (abort_ok) begin
								armed_q <= 1'b0;
								pend_q <= 1'b0;
							end else if (pwdata[`CMB_TCR_BIT]) begin
								armed_q <= 1'b1;
								rsent_q <= 1'b0;
								pend_q <= 1'b0;
							end
							if (is_tx || is_prod)
								length_code_field_q <= pwdata[`CMB_DLC_MSB:`CMB_DLC_LSB];
							if (is_tx)
								remote_request_bit_q <= pwdata[`CMB_RTR_BIT];
						end
						// hardware events come after the command so a set wins
						if (sent) begin
							if (is_cons) begin
								rsent_q <= 1'b1;
							end else begin
								mailbox_ready_flag_q <= 1'b1;
								armed_q <= 1'b0;
								pend_q <= 1'b0;
							end
						end
						if (store) begin
							mailbox_ready_flag_q <= 1'b1;
							payload_low_value_q <= rx_data[31:0];
							payload_high_value_q <= rx_data[63:32];
							length_code_field_q <= rx_dlc;
							if (!is_cons)
								remote_request_bit_q <= rx_rtr;
						end
						if (prod_take)
							pend_q <= 1'b1;
						if (wr_low && mailbox_ready_flag_q && !store)
							payload_low_value_q <= pwdata;
						if (wr_high && mailbox_ready_flag_q && !store)
							payload_high_value_q <= pwdata;
					end
					// only a flag that was reported is cleared; a new one stays
					message_ignored_flag_q <= ign_set || (message_ignored_flag_q
						&& !(rd_stat && prdata[`CMB_MMI_BIT]));
				end
			end

			// priority is widened first so that a narrower field still lands in place
			wire [31:0] prio_field = {{(32-PRIO_W){1'b0}}, prio_q} << `CMB_PRIO_LSB;

			// no timestamp is kept here: the low half of the status word reads zero
			assign stat_w[i*32 +: 32] = {7'h00, message_ignored_flag_q, mailbox_ready_flag_q,
				mailbox_abort_flag_q, 1'b0, remote_request_bit_q, length_code_field_q, 16'h0000};
			assign mode_w[i*32 +: 32] = {5'h00, object_type_field_q, 24'h000000} | prio_field;
			assign pay_w[i*64 +: 64] = {payload_high_value_q, payload_low_value_q};
			assign rdy_w[i] = mailbox_ready_flag_q;
			assign req_w[i] = armed_q && !inflight && !abort_ok
				&& (is_tx || (is_cons && !rsent_q) || (is_prod && pend_q));
			assign take_w[i] = store || prod_take;
			assign irq_d[i] = mailbox_ready_flag_q || mailbox_abort_flag_q;
			assign prio_w[i*PRIO_W +: PRIO_W] = prio_q;
			assign mot_w[i*3 +: 3] = object_type_field_q;
			assign rtr_w[i] = remote_request_bit_q;
			assign dlc_w[i*4 +: 4] = length_code_field_q;
		end
	endgenerate

	// ****************************************
	// transmit scheduling
	// ****************************************
	wire arb_any;
	wire [MB_W-1:0] arb_grant;

	cmb_tx_arbiter #(
		.NUM_MB(NUM_MB),
		.MB_W(MB_W),
		.PRIO_W(PRIO_W)
	) u_arb (
		.req(req_w),
		.prio(prio_w),
		.any(arb_any),
		.grant(arb_grant)
	);

	wire [2:0] g_mot = mot_w[arb_grant*3 +: 3];

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 1'b0;
			cur_mb_q <= {MB_W{1'b0}};
			tx_req <= 1'b0;
			tx_mb <= {MB_W{1'b0}};
			tx_rtr <= 1'b0;
			tx_dlc <= `CMB_ZERO4;
			tx_data <= {`CMB_ZERO32, `CMB_ZERO32};
			rx_taken <= 1'b0;
			rx_ignored <= 1'b0;
			mb_irq <= {NUM_MB{1'b0}};
		end else begin
			if (tx_start && tx_req) begin
				busy_q <= 1'b1;
				cur_mb_q <= tx_mb;
			end else if (tx_done) begin
				busy_q <= 1'b0;
			end
			// request is one cycle behind the arbiter; a start always wins
			tx_req <= arb_any && !busy_q && !(tx_start && tx_req);
			tx_mb <= arb_grant;
			tx_rtr <= (g_mot == `CMB_MOT_CONS)
				|| (g_mot == `CMB_MOT_TX && rtr_w[arb_grant]);
			tx_dlc <= dlc_w[arb_grant*4 +: 4];
			tx_data <= pay_w[arb_grant*64 +: 64];
			rx_taken <= rx_valid && (|take_w);
			rx_ignored <= rx_valid && !(|take_w);
			mb_irq <= irq_d;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	// no wait state: read data is captured at setup so it comes from a flop
	// status writes are dropped without an error; those flags belong to hardware
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= `CMB_ZERO32;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= `CMB_ZERO32;
				pslverr <= 1'b0;
				if (acc_reg == `CMB_REG_NONE) begin
					pslverr <= 1'b1;
				end else if ((acc_reg == `CMB_REG_PLOW || acc_reg == `CMB_REG_PHIGH)
					&& !rdy_w[acc_mb]) begin
					pslverr <= 1'b1;
				end else if (!pwrite && acc_reg == `CMB_REG_STAT) begin
					prdata <= stat_w[acc_mb*32 +: 32];
				end else if (!pwrite && acc_reg == `CMB_REG_MODE) begin
					prdata <= mode_w[acc_mb*32 +: 32];
				end else if (!pwrite && acc_reg == `CMB_REG_PLOW) begin
					prdata <= pay_w[acc_mb*64 +: 32];
				end else if (!pwrite && acc_reg == `CMB_REG_PHIGH) begin
					prdata <= pay_w[acc_mb*64+32 +: 32];
				end
			end
		end
	end
endmodule

// file: tb/cmb_monitor.sv
`timescale 1ns/1ns
// ****
// port checker
// ****
module cmb_monitor #(
	parameter NUM_MB = 8,
	parameter MB_W = 3
) (
	// clock and reset
	input wire clock,
	input wire arst_n,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// engine side
	input wire rx_valid,
	input wire [MB_W-1:0] rx_mb,
	input wire rx_rtr,
	input wire rx_taken,
	input wire rx_ignored,
	input wire tx_req,
	input wire [63:0] tx_data,
	input wire tx_start,
	input wire tx_done,
	input wire [NUM_MB-1:0] mb_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_pready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_pready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_rx_one_answer: assert property (rx_valid |=> rx_taken != rx_ignored)
		else $error("frame not answered once");
	a_rx_no_spurious: assert property (!rx_valid |=> !rx_taken && !rx_ignored)
		else $error("answer without frame");
	a_tx_drop_start: assert property (tx_req && tx_start |=> !tx_req)
		else $error("request kept after start");
	a_tx_hold_req: assert property (tx_req && !tx_start && !psel |=> tx_req && $stable(tx_data))
		else $error("request not held");
	a_cmd_reads_zero: assert property (psel && penable && pready && !pwrite
		&& paddr[4:0] == 5'h1c |-> prdata == 32'h0)
		else $error("command read not zero");
	a_irq_on_ready: assert property (rx_taken && !$past(rx_rtr) |=> mb_irq[$past(rx_mb, 2)])
		else $error("no interrupt after frame");
	// the main paths must be reached, or the checks above prove little
	c_ignored: cover property (rx_ignored);
	c_tx_done: cover property (tx_done);
	c_error: cover property (pready && pslverr);
endmodule

bind cmb_mailbox cmb_monitor #(.NUM_MB(NUM_MB), .MB_W(MB_W)) i_mon (.clock, .arst_n, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .rx_valid, .rx_mb, .rx_rtr,
	.rx_taken, .rx_ignored, .tx_req, .tx_data, .tx_start, .tx_done, .mb_irq);

// file: tb/cmb_engine_model.sv
`timescale 1ns/1ns
// ****
// protocol engine stand-in
// ****
module cmb_engine_model #(
	parameter START_DLY = 3,
	parameter FRAME_LEN = 8
) (
	// clock and reset
	input wire clock,
	input wire arst_n,
	// frames offered
	output reg rx_valid = 1'b0,
	output reg [2:0] rx_mb = 3'h0,
	output reg rx_rtr = 1'b0,
	output reg [3:0] rx_dlc = 4'h0,
	output reg [63:0] rx_data = 64'h0,
	input wire rx_taken,
	input wire rx_ignored,
	// transmit
	input wire tx_req,
	output reg tx_start = 1'b0,
	output reg tx_done = 1'b0
);
	reg [7:0] wait_q;
	reg [7:0] busy_q;
	task offer(input [2:0] m, input r, input [3:0] l, input [63:0] d, output t, output i);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_mb <= m;
		rx_rtr <= r;
		rx_dlc <= l;
		rx_data <= d;
		@(posedge clock);
		rx_valid <= 1'b0;
		// stale data must not look valid
		rx_data <= ~d;
		@(posedge clock);
		t = rx_taken;
		i = rx_ignored;
	endtask
	// one frame in flight; start comes late on purpose
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tx_start <= 1'b0;
			tx_done <= 1'b0;
			wait_q <= 8'h0;
			busy_q <= 8'h0;
		end else begin
			tx_start <= 1'b0;
			tx_done <= 1'b0;
			if (busy_q != 8'h0) begin
				busy_q <= busy_q - 8'h1;
				tx_done <= (busy_q == 8'h1);
			end else if (tx_req && wait_q == START_DLY) begin
				tx_start <= 1'b1;
				busy_q <= FRAME_LEN;
				wait_q <= 8'h0;
			end else begin
				wait_q <= tx_req ? wait_q + 8'h1 : 8'h0;
			end
		end
	end
endmodule

// file: tb/can_mailbox_status_data_tb.sv
`timescale 1ns/1ns
module can_mailbox_status_data_tb;
	localparam [31:0] RDY = 32'h00800000;
	localparam [31:0] ABT = 32'h00400000;
	localparam [31:0] MESSAGE_IGNORED_FLAG = 32'h01000000;
	localparam [31:0] FL = 32'h01c00000;
	localparam [63:0] FA = 64'h11112222_33334444;
	localparam [63:0] FB = 64'h55556666_77778888;
	reg clock = 1'b0;
	reg arst_n = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, rx_valid, rx_rtr, rx_taken, rx_ignored, tx_req, tx_rtr, tx_start, tx_done;
	wire [2:0] rx_mb, tx_mb;
	wire [3:0] rx_dlc, tx_dlc;
	wire [63:0] rx_data, tx_data;
	wire [7:0] mb_irq;
	integer failures = 0;
	integer cmp_count = 0;
	reg [31:0] rv;
	reg re, tk, ig;
	always #25 clock = ~clock;
	cmb_mailbox i_dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rx_valid, .rx_mb, .rx_rtr, .rx_dlc, .rx_data, .rx_taken,
		.rx_ignored, .tx_req, .tx_mb, .tx_rtr, .tx_dlc, .tx_data, .tx_start, .tx_done, .mb_irq);
	cmb_engine_model #(.START_DLY(5)) i_eng (.clock, .arst_n, .rx_valid, .rx_mb, .rx_rtr,
		.rx_dlc, .rx_data, .rx_taken, .rx_ignored, .tx_req, .tx_start, .tx_done);
	task chk(input [63:0] got, input [63:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function [11:0] ra(input [2:0] m, input [4:0] o);
		ra = 12'h200 + {4'h0, m, 5'h00} + {7'h0, o};
	endfunction
	// request held until pready is seen high at an edge
	task apb(input w, input [11:0] a, input [31:0] d);
		integer n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		@(posedge clock);
		while (pready !== 1'b1 && n < 20) begin
			n = n + 1;
			@(posedge clock);
		end
		chk(pready, 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdm(input [11:0] a, input [31:0] m, input [31:0] e, input ee);
		apb(1'b0, a, 32'h0);
		chk(rv & m, e);
		chk(re, ee);
	endtask
	task t_receive;
		apb(1'b1, ra(0, 5'h00), 32'h01000000);
		rdm(ra(0, 5'h10), FL, 32'h0, 1'b0);
		rdm(ra(0, 5'h14), 32'hffffffff, 32'h0, 1'b1);
		apb(1'b1, ra(0, 5'h1c), 32'h00800000);
		i_eng.offer(3'd0, 1'b0, 4'h8, FA, tk, ig);
		chk({tk, ig}, 2'b10);
		i_eng.offer(3'd0, 1'b0, 4'h2, FB, tk, ig);
		chk({tk, ig}, 2'b01);
		chk(mb_irq[0], 1'b1);
		rdm(ra(0, 5'h10), 32'h01df0000, 32'h01880000, 1'b0);
		rdm(ra(0, 5'h14), 32'hffffffff, FA[31:0], 1'b0);
		rdm(ra(0, 5'h18), 32'hffffffff, FA[63:32], 1'b0);
		rdm(ra(0, 5'h10), MESSAGE_IGNORED_FLAG, 32'h0, 1'b0);
		apb(1'b1, ra(0, 5'h1c), 32'h0);
		rdm(ra(0, 5'h10), FL, 32'h0, 1'b0);
		chk(mb_irq[0], 1'b0);
		$display("test receive done");
	endtask
	task t_overwrite;
		apb(1'b1, ra(1, 5'h00), 32'h02000000);
		apb(1'b1, ra(1, 5'h1c), 32'h00800000);
		i_eng.offer(3'd1, 1'b0, 4'h8, FA, tk, ig);
		i_eng.offer(3'd1, 1'b0, 4'h8, FB, tk, ig);
		rdm(ra(1, 5'h14), 32'hffffffff, FB[31:0], 1'b0);
		rdm(ra(1, 5'h18), 32'hffffffff, FB[63:32], 1'b0);
		rdm(ra(1, 5'h10), FL, MESSAGE_IGNORED_FLAG | RDY, 1'b0);
		// ignored was found set, so both words are read again
		rdm(ra(1, 5'h14), 32'hffffffff, FB[31:0], 1'b0);
		rdm(ra(1, 5'h18), 32'hffffffff, FB[63:32], 1'b0);
		rdm(ra(1, 5'h10), FL, RDY, 1'b0);
		$display("test overwrite done");
	endtask
	// waits for one frame and checks what stands at the start edge
	task wait_tx(input [2:0] m, input r, input [3:0] l, input [63:0] d);
		integer n;
		integer s;
		n = 0;
		s = 0;
		while (tx_done !== 1'b1 && n < 100) begin
			if (tx_start === 1'b1) begin
				s = s + 1;
				chk({tx_mb, tx_rtr, tx_dlc}, {m, r, l});
				chk(tx_data, d);
			end
			n = n + 1;
			@(posedge clock);
		end
		chk(n < 100, 1'b1);
		chk(s, 1);
	endtask
	task t_transmit;
		apb(1'b1, ra(2, 5'h00), 32'h03000000);
		rdm(ra(2, 5'h10), FL, RDY, 1'b0);
		apb(1'b1, ra(2, 5'h14), 32'h0badcafe);
		apb(1'b1, ra(2, 5'h18), 32'h12345678);
		apb(1'b1, ra(2, 5'h1c), 32'h00830000);
		wait_tx(3'd2, 1'b0, 4'h3, 64'h12345678_0badcafe);
		repeat (3) @(posedge clock);
		rdm(ra(2, 5'h10), FL, RDY, 1'b0);
		$display("test transmit done");
	endtask
	task t_abort;
		apb(1'b1, ra(3, 5'h00), 32'h03000000);
		apb(1'b1, ra(3, 5'h1c), 32'h00800000);
		// the abort must land before the engine hands the frame on
		apb(1'b1, ra(3, 5'h1c), 32'h00400000);
		@(posedge clock);
		chk(tx_req, 1'b0);
		rdm(ra(3, 5'h10), FL, ABT, 1'b0);
		chk(mb_irq[3], 1'b1);
		$display("test abort done");
	endtask
	task t_misc;
		apb(1'b1, ra(4, 5'h00), 32'h05000000);
		i_eng.offer(3'd4, 1'b1, 4'h0, FA, tk, ig);
		chk({tk, ig}, 2'b01);
		rdm(ra(4, 5'h10), FL, MESSAGE_IGNORED_FLAG | RDY, 1'b0);
		apb(1'b1, ra(4, 5'h14), 32'h0000beef);
		apb(1'b1, ra(4, 5'h18), 32'h0000cafe);
		apb(1'b1, ra(4, 5'h1c), 32'h00820000);
		i_eng.offer(3'd4, 1'b1, 4'h0, FB, tk, ig);
		chk({tk, ig}, 2'b10);
		wait_tx(3'd4, 1'b0, 4'h2, 64'h0000cafe_0000beef);
		repeat (3) @(posedge clock);
		rdm(ra(4, 5'h10), FL, RDY, 1'b0);
		rdm(ra(0, 5'h1c), 32'hffffffff, 32'h0, 1'b0);
		rdm(12'h000, 32'hffffffff, 32'h0, 1'b1);
		$display("test misc done");
	endtask
	task t_consumer;
		apb(1'b1, ra(5, 5'h00), 32'h04000000);
		apb(1'b1, ra(5, 5'h1c), 32'h00800000);
		wait_tx(3'd5, 1'b1, 4'h0, 64'h0);
		i_eng.offer(3'd5, 1'b0, 4'h8, FA, tk, ig);
		chk({tk, ig}, 2'b10);
		i_eng.offer(3'd5, 1'b0, 4'h2, FB, tk, ig);
		chk({tk, ig}, 2'b01);
		rdm(ra(5, 5'h10), 32'h01df0000, 32'h01980000, 1'b0);
		rdm(ra(5, 5'h14), 32'hffffffff, FA[31:0], 1'b0);
		$display("test consumer done");
	endtask
	task print_verdict;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		chk({tx_req, mb_irq}, 9'h0);
		t_receive;
		t_overwrite;
		t_transmit;
		t_abort;
		t_misc;
		t_consumer;
		print_verdict;
	end
	// all tests need well under a thousand cycles
	initial begin
		#100000;
		failures = failures + 1;
		print_verdict;
	end
endmodule
